/* dv/smsm_chk.sv */
// Port checker for the supply mode state machine
`timescale 1ns/10ps
module smsm_chk
  import smsm_pkg::*;
(
  input wire logic                sys_clk, arst_n, psel, penable, pready, main_rail_en,
  input wire logic                aux_rail_en, boost_en, reset_out_pin_n, fail_outputs,
  input wire logic                static_sense, hv_wake_input_en,
  input wire logic [2*XCVR_N-1:0] xcvr_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // =====
  // Rail-off, fail-safe, restart and command answer checks
  a_sleep_reset_low: assert property (!main_rail_en |-> !reset_out_pin_n)
    else $error("reset high with rail off");
  a_sleep_no_answer: assert property (!main_rail_en |-> !pready)
    else $error("answer with rail off");
  a_sleep_boost_off: assert property (!main_rail_en |-> !boost_en)
    else $error("boost on with rail off");
  a_sleep_wake_cap: assert property (!main_rail_en |-> !(|(xcvr_mode & 6'h2a)))
    else $error("transceiver active with rail off");
  a_fs_outputs_set: assert property (static_sense |-> fail_outputs && !aux_rail_en
    && hv_wake_input_en && xcvr_mode == 6'h15)
    else $error("fail-safe outputs wrong");
  a_fail_out_sticky: assert property ($fell(fail_outputs) |-> !reset_out_pin_n)
    else $error("fail outputs dropped while running");
  a_restart_aux_off: assert property (!reset_out_pin_n && main_rail_en |-> !aux_rail_en)
    else $error("aux on during reset");
  a_cmd_answered: assert property (psel && !penable && reset_out_pin_n |=> pready)
    else $error("command not answered");
  c_failsafe: cover property (static_sense);
  c_sleep: cover property ($fell(main_rail_en) && !static_sense);
  c_release: cover property ($rose(reset_out_pin_n));
endmodule : smsm_chk
bind smsm_top smsm_chk u_chk (.*);

/* dv/smsm_host.sv */
// Host controller model: APB master toward the mode controller
`timescale 1ns/10ps
module smsm_host (
  input  wire logic        sys_clk, pready, pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel, penable, pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : smsm_host

/* dv/smsm_top_tb.sv */
// Self-checking bench for the supply mode state machine
`timescale 1ns/10ps
module smsm_top_tb;
  import smsm_pkg::*;
  logic        sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, main_uv, main_ov, e;
  logic        main_short, overtemp_level2, watchdog_fail_field, test_strap_pin, main_rail_en, aux_rail_en;
  logic        boost_en, reset_out_pin_n, fail_outputs, static_sense, hv_wake_input_en;
  logic [3:0]  wake_in;
  logic [5:0]  xcvr_mode;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          miscompares, n_tests;
  smsm_top #(.RESET_DELAY(28'd20), .THERMAL_HOLD(28'd200), .FAILSAFE_MIN_HOLD(28'd100)) dut (.*);
  smsm_host host (.*);
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, e);
  endtask : wr
  task wait_run;
    repeat (3) @(posedge sys_clk);
    do @(posedge sys_clk); while (reset_out_pin_n !== 1'b1);
  endtask : wait_run
  task clear_flags;
    wr(ADDR_DEV_STATUS, 32'hffffffff);
    wr(ADDR_WAKE_STAT_A, 32'hffffffff);
    wr(ADDR_WAKE_STAT_B, 32'hffffffff);
  endtask : clear_flags
  task wake(input logic [3:0] m);
    @(posedge sys_clk);
    wake_in <= m;
    repeat (4) @(posedge sys_clk);
    wake_in <= 4'h0;
  endtask : wake
  task t_init;
    host.xfer(1'b0, 8'h20, 32'h0, rd, e);
    chk(e, 1);
    host.xfer(1'b0, ADDR_CUR_MODE, 32'h0, rd, e);
    chk(rd[2:0], 3'h1);
    $display("init done");
  endtask : t_init
  task t_sleep;
    clear_flags;
    wr(ADDR_SUPPLY_CTRL, 32'h1);
    wr(ADDR_XCVR_CTRL, 32'h0d);
    wr(ADDR_MODE_CTRL, 32'(CMD_SLEEP));
    repeat (3) @(posedge sys_clk);
    chk({reset_out_pin_n, main_rail_en, boost_en, aux_rail_en, xcvr_mode}, 10'h045);
    wake(4'h2);
    wait_run;
    host.xfer(1'b0, ADDR_DEV_STATUS, 32'h0, rd, e);
    chk(rd[3:0], 4'h1);
    host.xfer(1'b0, ADDR_WAKE_STAT_A, 32'h0, rd, e);
    chk(rd[3:0], 4'h2);
    $display("sleep done");
  endtask : t_sleep
  task t_stop_sleep;
    wr(ADDR_MODE_CTRL, 32'(CMD_SLEEP));
    repeat (3) @(posedge sys_clk);
    chk({reset_out_pin_n, main_rail_en}, 2'b01);
    wait_run;
    clear_flags;
    wr(ADDR_MODE_CTRL, 32'(CMD_STOP));
    wr(ADDR_MODE_CTRL, 32'(CMD_SLEEP));
    repeat (3) @(posedge sys_clk);
    chk({reset_out_pin_n, main_rail_en}, 2'b01);
    wait_run;
    host.xfer(1'b0, ADDR_DEV_STATUS, 32'h0, rd, e);
    chk({rd[8], rd[1:0]}, 3'b101);
    main_uv <= 1'b1;
    repeat (4) @(posedge sys_clk);
    main_uv <= 1'b0;
    wait_run;
    host.xfer(1'b0, ADDR_DEV_STATUS, 32'h0, rd, e);
    chk({rd[5:4], rd[1:0]}, 4'b0101);
    $display("stop sleep done");
  endtask : t_stop_sleep
  task t_failsafe;
    clear_flags;
    main_short <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({static_sense, fail_outputs, reset_out_pin_n}, 3'b110);
    main_short <= 1'b0;
    wake(4'h8);
    repeat (60) @(posedge sys_clk);
    chk(static_sense, 1);
    wait_run;
    chk(fail_outputs, 1);
    host.xfer(1'b0, ADDR_DEV_STATUS, 32'h0, rd, e);
    chk({rd[6], rd[4], rd[1:0]}, 4'b1101);
    $display("fail-safe done");
  endtask : t_failsafe
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  initial begin
    #100us;
    miscompares++;
    stop_test;
  end
  initial begin
    {arst_n, main_uv, main_ov, main_short, overtemp_level2, watchdog_fail_field, wake_in} = '0;
    test_strap_pin = 1'b1;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_init;
    t_sleep;
    t_stop_sleep;
    t_failsafe;
    stop_test;
  end
endmodule : smsm_top_tb

/* include/smsm_pkg.sv */
// Package for the supply mode state machine: register map, fields, modes, timing
package smsm_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_FREQ_HZ         = 100_000_000;
  localparam int unsigned RESET_DELAY_US      = 10;
  localparam int unsigned THERMAL_HOLD_MS     = 1000;
  localparam int unsigned FAILSAFE_MIN_MS     = 100;
  localparam int unsigned RESET_DELAY_CYC     = (RESET_DELAY_US * (CLK_FREQ_HZ / 1_000_000));
  localparam longint unsigned THERMAL_HOLD_CYC =
    longint'(THERMAL_HOLD_MS) * longint'(CLK_FREQ_HZ / 1000);
  localparam longint unsigned FAILSAFE_MIN_CYC =
    longint'(FAILSAFE_MIN_MS) * longint'(CLK_FREQ_HZ / 1000);
  localparam int unsigned MAX_WD_RESETS       = 3;

  // ==========================================================
  // APB register offsets (byte addresses)
  localparam logic [7:0] ADDR_MODE_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_DEV_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_WAKE_STAT_A = 8'h08;
  localparam logic [7:0] ADDR_WAKE_STAT_B = 8'h0c;
  localparam logic [7:0] ADDR_WATCHDOG_CONTROL_REG     = 8'h10;
  localparam logic [7:0] ADDR_XCVR_CTRL   = 8'h14;
  localparam logic [7:0] ADDR_SUPPLY_CTRL = 8'h18;
  localparam logic [7:0] ADDR_CUR_MODE    = 8'h1c;

  // ==========================================================
  // Mode control: mode command field
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned MODE_W   = 3;
  localparam logic [2:0] CMD_NORMAL = 3'h0;
  localparam logic [2:0] CMD_SLEEP  = 3'h1;
  localparam logic [2:0] CMD_STOP   = 3'h2;
  localparam logic [2:0] CMD_SWRST  = 3'h3;

  // Device status register fields
  localparam int unsigned ST_DEV_LSB   = 0;  // device_status_field [1:0]
  localparam int unsigned ST_WDF_LSB   = 2;  // watchdog_fail_field [3:2]
  localparam int unsigned ST_UV_BIT    = 4;
  localparam int unsigned ST_OV_BIT    = 5;
  localparam int unsigned ST_SC_BIT    = 6;
  localparam int unsigned ST_OT_BIT    = 7;
  localparam int unsigned ST_SPIF_BIT  = 8;
  localparam int unsigned ST_DEVM_BIT  = 9;
  localparam logic [1:0] DEVICE_STATUS_FIELD_RESTARTED = 2'h1;
  localparam logic [1:0] DEVICE_STATUS_FIELD_CLEAR     = 2'h0;

  // Watchdog control fields
  localparam int unsigned WD_RSTLIM_BIT = 0;

  // Supply control fields
  localparam int unsigned SUP_AUX_BIT   = 0;
  localparam int unsigned SUP_BOOST_BIT = 1;
  localparam int unsigned SUP_OVRST_BIT = 2;

  // Wake source indices
  localparam int unsigned WAKE_N   = 4;  // can, lin1, lin2, hv wake input
  localparam int unsigned WAKE_CAN = 0;

  // Transceiver modes, 2 bits each, 3 transceivers (can, lin1, lin2)
  localparam int unsigned XCVR_N = 3;
  localparam logic [1:0] XCVR_OFF     = 2'h0;
  localparam logic [1:0] XCVR_WAKECAP = 2'h1;
  localparam logic [1:0] XCVR_RXONLY  = 2'h2;
  localparam logic [1:0] XCVR_NORMAL  = 2'h3;

  // ==========================================================
  // Operating modes
  typedef enum logic [2:0] {
    SMSM_INIT, SMSM_NORMAL, SMSM_STOP, SMSM_SLEEP,
    SMSM_RESTART, SMSM_FAILSAFE, SMSM_DEVEL
  } smsm_mode_t;

  // Restart causes
  typedef enum logic [2:0] {
    SMSM_C_NONE, SMSM_C_WD, SMSM_C_UV, SMSM_C_OV, SMSM_C_WAKE, SMSM_C_OT, SMSM_C_SC, SMSM_C_SPI
  } smsm_cause_t;

endpackage : smsm_pkg

/* logic/smsm_sync.sv */
// Two-flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/10ps
module smsm_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule : smsm_sync

/* logic/smsm_timer.sv */
// Down counter for hold times: load, count, done level
`timescale 1ns/10ps
module smsm_timer #(
  parameter int unsigned W = 28
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // Status
  output logic              done
);

  logic [W-1:0] cnt;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt  <= '0;
      done <= 1'b0;
    end else if (load) begin
      cnt  <= load_val;
      done <= 1'b0;
    end else if (cnt != '0) begin
      cnt  <= cnt - W'(1);
      done <= (cnt == W'(1));
    end else begin
      done <= 1'b1;
    end
  end

endmodule : smsm_timer

/* logic/smsm_top.sv */
// Supply mode state machine with APB register file
// Behaviour
// RULE_01 - Sleep wake on can, lin or wake input goes via restart; source recorded
// RULE_02 - Sleep turns off main and boost; aux, lin, wake input kept
// RULE_03 - Host sets can wake capable or off before commanding sleep
// RULE_04 - Entering sleep, normal or receive-only transceivers become wake capable
// RULE_05 - In sleep, serial commands ignored with no response
// RULE_06 - Pending wake flags at sleep command cause immediate restart
// RULE_07 - Reset output goes low when sleep command accepted
// RULE_08 - Restart entry causes from normal, stop, sleep and fail-safe
// RULE_09 - Status after restart: device 01, watchdog fail, under/over voltage bits
// RULE_10 - Reset limit set: no watchdog resets after three consecutive
// RULE_11 - Restart exits to normal after cause clears and delay; reset released
// RULE_12 - Restart holds reset low, aux off, boost kept, serial ignored
// RULE_13 - Restart: active transceivers wake capable, others off or woken
// RULE_14 - Passing through restart shown in device status field
// RULE_15 - Overvoltage reset disabled after reset; only when enabled
// RULE_16 - Overtemp level 2 or main short enters fail-safe; regulators off
// RULE_17 - Fail-safe holds 1 s thermal, 100 ms other; wakes stored
// RULE_18 - Fail outputs set in fail-safe; restart never clears them
// RULE_19 - Fail-safe: all wake capable, static sense, regulators off, serial off
// RULE_20 - After fail-safe: device 01, overtemp or undervolt plus short
// RULE_21 - Test strap low in init plus any command enters development mode
// RULE_22 - Software reset ends development mode and blocks it afterwards
// RULE_23 - Sleep from stop sets serial failure and enters restart
// RULE_24 - In init any serial command moves to normal
// RULE_25 - One synchronous state machine with seven modes
`timescale 1ns/10ps
module smsm_top
  import smsm_pkg::*;
#(
  parameter int unsigned   TW                = 28,
  parameter logic [TW-1:0] RESET_DELAY       = TW'(RESET_DELAY_CYC),
  parameter logic [TW-1:0] THERMAL_HOLD      = TW'(THERMAL_HOLD_CYC),
  parameter logic [TW-1:0] FAILSAFE_MIN_HOLD = TW'(FAILSAFE_MIN_CYC)
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  arst_n,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Asynchronous monitor and wake inputs
  input  wire logic [WAKE_N-1:0]     wake_in,
  input  wire logic                  main_uv,
  input  wire logic                  main_ov,
  input  wire logic                  main_short,
  input  wire logic                  overtemp_level2,
  input  wire logic                  watchdog_fail_field,
  input  wire logic                  test_strap_pin,
  // Supply and pin controls
  output logic                       main_rail_en,
  output logic                       aux_rail_en,
  output logic                       boost_en,
  output logic                       reset_out_pin_n,
  output logic                       fail_outputs,
  output logic                       static_sense,
  output logic [2*XCVR_N-1:0]        xcvr_mode,
  output logic                       hv_wake_input_en
);

  // ========================================================
  // Input synchronisation
  localparam int unsigned SW = WAKE_N + 6;
  logic [SW-1:0] raw_in;
  logic [SW-1:0] syn_in;
  assign raw_in = {test_strap_pin, watchdog_fail_field, overtemp_level2, main_short, main_ov, main_uv,
                   wake_in};

  smsm_sync #(.W(SW)) u_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .d       (raw_in),
    .q       (syn_in)
  );

  wire [WAKE_N-1:0] s_wake  = syn_in[WAKE_N-1:0];
  wire              s_uv    = syn_in[WAKE_N];
  wire              s_ov    = syn_in[WAKE_N+1];
  wire              s_sc    = syn_in[WAKE_N+2];
  wire              s_ot    = syn_in[WAKE_N+3];
  wire              s_wdf   = syn_in[WAKE_N+4];
  wire              s_test  = syn_in[WAKE_N+5];

  // ========================================================
  // State and registers
  smsm_mode_t          mode;
  smsm_mode_t          next_mode;
  smsm_cause_t         cause;
  logic [WAKE_N-1:0]   wake_stat_a;
  logic [WAKE_N-1:0]   wake_stat_b;
  logic [2*XCVR_N-1:0] xcvr_cfg;
  logic                aux_cfg;
  logic                boost_cfg;
  logic                ovrst_en;
  logic                rst_limit;
  logic [1:0]          device_status_field;
  logic [1:0]          wdf_field;
  logic                uv_flag;
  logic                ov_flag;
  logic                sc_flag;
  logic                ot_flag;
  logic                spi_fail;
  logic                swrst_seen;
  logic [1:0]          wd_rst_cnt;
  logic                wdf_q;
  logic                tmr_load;
  logic [TW-1:0]       tmr_val;
  logic                tmr_done;

  smsm_timer #(.W(TW)) u_timer (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // ========================================================
  // APB decode
  wire       apb_acc  = psel && penable;
  wire       serial_off = (mode == SMSM_SLEEP) || (mode == SMSM_RESTART)
                          || (mode == SMSM_FAILSAFE);                     // RULE_05 RULE_12 RULE_19
  wire       apb_wr   = apb_acc && pwrite && !serial_off;
  wire       apb_any  = apb_acc && !serial_off;
  wire       wr_mode  = apb_wr && (paddr == ADDR_MODE_CTRL);
  wire [2:0] cmd      = pwdata[MODE_LSB +: MODE_W];
  wire       cmd_sleep = wr_mode && (cmd == CMD_SLEEP);
  wire       cmd_swrst = wr_mode && (cmd == CMD_SWRST);
  wire       stop_wr_ok = (paddr == ADDR_MODE_CTRL) || (paddr == ADDR_WAKE_STAT_A)
                          || (paddr == ADDR_WAKE_STAT_B);
  wire       stop_bad  = apb_wr && (mode == SMSM_STOP) && !stop_wr_ok;
  wire       map_hit   = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);

  // Event decoding
  wire       wd_event  = s_wdf && !wdf_q;
  wire       wd_limited = rst_limit && (wd_rst_cnt == 2'(MAX_WD_RESETS));  // RULE_10
  wire       wd_reset  = wd_event && !wd_limited;
  wire       run_mode  = (mode == SMSM_NORMAL) || (mode == SMSM_STOP) || (mode == SMSM_DEVEL);
  wire       fs_cause  = s_ot || s_sc;                                    // RULE_16
  wire       rst_cause = s_uv || (s_ov && ovrst_en);                      // RULE_15
  wire       wake_pend = |wake_stat_a || |wake_stat_b;

  // ========================================================
  // Next mode
  always_comb begin
    next_mode = mode;
    case (mode)
      SMSM_INIT: begin
        if (fs_cause) begin
          next_mode = SMSM_FAILSAFE;
        end else if (apb_any) begin
          next_mode = (!s_test && !swrst_seen) ? SMSM_DEVEL : SMSM_NORMAL; // RULE_21 RULE_24
        end
      end
      SMSM_NORMAL, SMSM_STOP, SMSM_DEVEL: begin
        if (fs_cause) begin
          next_mode = SMSM_FAILSAFE;                                     // RULE_16
        end else if (cmd_swrst) begin
          next_mode = SMSM_INIT;                                         // RULE_22
        end else if (rst_cause || (wd_reset && mode != SMSM_DEVEL)) begin
          next_mode = SMSM_RESTART;                                      // RULE_08 RULE_21
        end else if (cmd_sleep) begin
          next_mode = (mode == SMSM_STOP || wake_pend) ? SMSM_RESTART
                                                       : SMSM_SLEEP;     // RULE_06 RULE_23
        end else if (wr_mode && cmd == CMD_STOP) begin
          next_mode = SMSM_STOP;
        end else if (wr_mode && cmd == CMD_NORMAL && mode == SMSM_STOP) begin
          next_mode = SMSM_NORMAL;
        end
      end
      SMSM_SLEEP: begin
        if (fs_cause) begin
          next_mode = SMSM_FAILSAFE;
        end else if (|s_wake) begin
          next_mode = SMSM_RESTART;                                      // RULE_01 RULE_08
        end
      end
      SMSM_FAILSAFE: begin
        if (tmr_done && !fs_cause && (wake_pend || |s_wake)) begin
          next_mode = SMSM_RESTART;                                      // RULE_17
        end
      end
      SMSM_RESTART: begin
        if (fs_cause) begin
          next_mode = SMSM_FAILSAFE;
        end else if (tmr_done && !rst_cause) begin
          next_mode = SMSM_NORMAL;                                       // RULE_11
        end
      end
      default: next_mode = SMSM_INIT;
    endcase
  end

  // Hold timer reloads on entry to restart or fail-safe
  assign tmr_load = (next_mode != mode)
                    && (next_mode == SMSM_RESTART || next_mode == SMSM_FAILSAFE);
  assign tmr_val  = (next_mode == SMSM_RESTART) ? RESET_DELAY
                  : (s_ot ? THERMAL_HOLD : FAILSAFE_MIN_HOLD);           // RULE_17

  // ========================================================
  // Mode state register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode  <= SMSM_INIT;                                                // RULE_25
      wdf_q <= 1'b0;
    end else begin
      mode  <= next_mode;
      wdf_q <= s_wdf;
    end
  end

  // Restart cause capture
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cause <= SMSM_C_NONE;
    end else if (next_mode == SMSM_FAILSAFE && mode != SMSM_FAILSAFE) begin
      cause <= s_ot ? SMSM_C_OT : SMSM_C_SC;
    end else if (next_mode == SMSM_RESTART && mode != SMSM_RESTART
                 && mode != SMSM_FAILSAFE) begin
      cause <= (mode == SMSM_SLEEP || cmd_sleep) && !rst_cause && !wd_reset ? SMSM_C_WAKE
             : s_uv      ? SMSM_C_UV
             : rst_cause ? SMSM_C_OV
             : wd_reset  ? SMSM_C_WD : SMSM_C_SPI;
    end
  end

  // ========================================================
  // Status flags; hardware set wins over software clear
  wire wr_status = apb_wr && (paddr == ADDR_DEV_STATUS);
  wire to_normal = (mode == SMSM_RESTART) && (next_mode == SMSM_NORMAL);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      device_status_field  <= DEVICE_STATUS_FIELD_CLEAR;
      wdf_field <= 2'h0;
      uv_flag   <= 1'b0;
      ov_flag   <= 1'b0;
      sc_flag   <= 1'b0;
      ot_flag   <= 1'b0;
    end else if (to_normal) begin
      device_status_field  <= DEVICE_STATUS_FIELD_RESTARTED;                                   // RULE_09 RULE_14
      wdf_field <= (cause == SMSM_C_WD) ? 2'(wd_rst_cnt) : 2'h0;         // RULE_09
      uv_flag   <= (cause == SMSM_C_UV) || (cause == SMSM_C_SC);         // RULE_09 RULE_20
      ov_flag   <= (cause == SMSM_C_OV);
      sc_flag   <= (cause == SMSM_C_SC);                                 // RULE_20
      ot_flag   <= (cause == SMSM_C_OT);                                 // RULE_20
    end else if (wr_status) begin
      device_status_field  <= device_status_field & ~pwdata[ST_DEV_LSB +: 2];
      wdf_field <= wdf_field & ~pwdata[ST_WDF_LSB +: 2];
      uv_flag   <= uv_flag & ~pwdata[ST_UV_BIT];
      ov_flag   <= ov_flag & ~pwdata[ST_OV_BIT];
      sc_flag   <= sc_flag & ~pwdata[ST_SC_BIT];
      ot_flag   <= ot_flag & ~pwdata[ST_OT_BIT];
    end
  end

  // Serial failure, software reset memory, watchdog reset count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      spi_fail   <= 1'b0;
      swrst_seen <= 1'b0;
      wd_rst_cnt <= 2'h0;
    end else begin
      if ((cmd_sleep && mode == SMSM_STOP) || stop_bad) begin
        spi_fail <= 1'b1;                                                // RULE_23
      end else if (wr_status && pwdata[ST_SPIF_BIT]) begin
        spi_fail <= 1'b0;
      end
      if (cmd_swrst) begin
        swrst_seen <= 1'b1;                                              // RULE_22
      end
      if (wd_reset && run_mode && mode != SMSM_DEVEL) begin
        wd_rst_cnt <= (wd_rst_cnt == 2'(MAX_WD_RESETS)) ? wd_rst_cnt : wd_rst_cnt + 2'h1;
      end else if (to_normal && cause != SMSM_C_WD) begin
        wd_rst_cnt <= 2'h0;
      end
    end
  end

  // Wake status: latched per source, set wins over write-one-to-clear
  wire wr_wka = apb_wr && (paddr == ADDR_WAKE_STAT_A);
  wire wr_wkb = apb_wr && (paddr == ADDR_WAKE_STAT_B);
  wire wake_a_set = (mode == SMSM_SLEEP) || (mode == SMSM_FAILSAFE);
  wire wake_b_set = run_mode;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_stat_a <= '0;
      wake_stat_b <= '0;
    end else begin
      wake_stat_a <= (wake_a_set ? s_wake : '0)
                   | (wake_stat_a & ~(wr_wka ? pwdata[WAKE_N-1:0] : '0));  // RULE_01 RULE_17
      wake_stat_b <= (wake_b_set ? s_wake : '0)
                   | (wake_stat_b & ~(wr_wkb ? pwdata[WAKE_N-1:0] : '0));
    end
  end

  // ========================================================
  // Configuration registers
  wire wr_xcvr = apb_wr && (paddr == ADDR_XCVR_CTRL) && (mode != SMSM_STOP);
  wire wr_sup  = apb_wr && (paddr == ADDR_SUPPLY_CTRL) && (mode != SMSM_STOP);
  wire wr_wd   = apb_wr && (paddr == ADDR_WATCHDOG_CONTROL_REG) && (mode != SMSM_STOP);

  // Transceiver modes for the next cycle
  logic [2*XCVR_N-1:0] next_xcvr_cfg;
  wire                 xcvr_fs   = (next_mode == SMSM_FAILSAFE);
  wire                 xcvr_park = (next_mode == SMSM_SLEEP) || (next_mode == SMSM_RESTART);

  for (genvar g = 0; g < XCVR_N; g++) begin : g_xcvr
    wire [1:0] cur  = wr_xcvr ? pwdata[2*g +: 2] : xcvr_cfg[2*g +: 2];
    wire       park = xcvr_park && (cur != XCVR_OFF);                        // RULE_04 RULE_13
    assign next_xcvr_cfg[2*g +: 2] = (xcvr_fs || park) ? XCVR_WAKECAP : cur; // RULE_19
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      xcvr_cfg  <= '0;
      aux_cfg   <= 1'b0;
      boost_cfg <= 1'b0;
      ovrst_en  <= 1'b0;                                                 // RULE_15
      rst_limit <= 1'b0;
    end else if (mode == SMSM_FAILSAFE) begin
      xcvr_cfg  <= next_xcvr_cfg;
      aux_cfg   <= 1'b0;
    end else begin
      xcvr_cfg  <= next_xcvr_cfg;
      if (wr_sup) begin
        aux_cfg   <= pwdata[SUP_AUX_BIT];
        boost_cfg <= pwdata[SUP_BOOST_BIT];
        ovrst_en  <= pwdata[SUP_OVRST_BIT];
      end else if (mode == SMSM_RESTART) begin
        aux_cfg   <= 1'b0;                                               // RULE_12
      end
      if (wr_wd) begin
        rst_limit <= pwdata[WD_RSTLIM_BIT];
      end
    end
  end

  // ========================================================
  // Pin outputs, all registered
  wire sup_off = (next_mode == SMSM_SLEEP) || (next_mode == SMSM_FAILSAFE);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      main_rail_en     <= 1'b1;
      aux_rail_en      <= 1'b0;
      boost_en         <= 1'b0;
      reset_out_pin_n  <= 1'b0;
      fail_outputs     <= 1'b0;
      static_sense     <= 1'b0;
      xcvr_mode        <= '0;
      hv_wake_input_en <= 1'b0;
    end else begin
      main_rail_en     <= !sup_off;                                      // RULE_02 RULE_16
      aux_rail_en      <= aux_cfg && !(next_mode inside {SMSM_RESTART, SMSM_FAILSAFE}); // RULE_12
      boost_en         <= boost_cfg && !sup_off;                         // RULE_02 RULE_12
      reset_out_pin_n  <= (next_mode != SMSM_SLEEP) && (next_mode != SMSM_RESTART)
                          && (next_mode != SMSM_FAILSAFE)
                          && !(mode == SMSM_INIT && !tmr_done);          // RULE_07 RULE_11
      if (next_mode == SMSM_FAILSAFE) begin
        fail_outputs <= 1'b1;                                            // RULE_18
      end else if (mode == SMSM_INIT) begin
        fail_outputs <= 1'b0;
      end
      static_sense     <= (mode == SMSM_FAILSAFE);                       // RULE_19
      xcvr_mode        <= next_xcvr_cfg;
      hv_wake_input_en <= (mode == SMSM_FAILSAFE) || (mode == SMSM_SLEEP)
                          || (mode == SMSM_NORMAL) || (mode == SMSM_STOP);
    end
  end

  // ========================================================
  // APB read path and answer
  wire [31:0] status_word = 32'({ (mode == SMSM_DEVEL), spi_fail, ot_flag, sc_flag,
                                  ov_flag, uv_flag, wdf_field, device_status_field });
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      ADDR_MODE_CTRL:   rd_mux = 32'h0;
      ADDR_DEV_STATUS:  rd_mux = status_word;
      ADDR_WAKE_STAT_A: rd_mux = 32'(wake_stat_a);
      ADDR_WAKE_STAT_B: rd_mux = 32'(wake_stat_b);
      ADDR_WATCHDOG_CONTROL_REG:     rd_mux = 32'(rst_limit);
      ADDR_XCVR_CTRL:   rd_mux = 32'(xcvr_cfg);
      ADDR_SUPPLY_CTRL: rd_mux = 32'({ovrst_en, boost_cfg, aux_cfg});
      ADDR_CUR_MODE:    rd_mux = 32'(mode);
      default:          rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable && !serial_off;                        // RULE_05
      pslverr <= psel && !penable && !map_hit;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
    end
  end

endmodule : smsm_top
